/* include/dsma_pkg.sv */
/*
 package for the serial media-access block: register map, field widths, reset values, timing units.
 assumes a 50 MHz core clock and APB register access with 32-bit data.
*/
`default_nettype none
package dsma_pkg;
   // ************************************************************
   // clock and time units
   // ************************************************************
   localparam int CLK_HZ = 50_000_000;
   localparam int TICK_MS = 1;
   localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
   // ************************************************************
   // register byte offsets
   // ************************************************************
   localparam logic [11:0] OFF_CTRL = 12'h000;
   localparam logic [11:0] OFF_IDLE = 12'h004;
   localparam logic [11:0] OFF_SETTLE = 12'h008;
   localparam logic [11:0] OFF_LINK = 12'h00C;
   localparam logic [11:0] OFF_EVENT = 12'h010;
   localparam logic [11:0] OFF_REPORT = 12'h014;
   localparam logic [11:0] OFF_CLASS = 12'h018;
   localparam logic [11:0] OFF_DBCUR = 12'h01C;
   localparam logic [11:0] OFF_DBVOLT = 12'h020;
   localparam logic [11:0] OFF_DBMISC = 12'h024;
   localparam logic [11:0] OFF_SBO = 12'h028;
   localparam logic [11:0] OFF_STATUS = 12'h02C;
   // ************************************************************
   // encodings and limits
   // ************************************************************
   localparam logic [1:0] PORT_PROTOCOL_SELECT_STANDARD = 2'h0;
   localparam logic [1:0] PORT_PROTOCOL_SELECT_EXTENDED = 2'h1;
   localparam logic [15:0] PRE_OFF = 16'hFFFF;
   localparam logic [15:0] PRE_MAX_MS = 16'h7530;
   localparam logic [15:0] POST_MAX_MS = 16'h7530;
   localparam logic [9:0] IDLE_MAX_MS = 10'h3E8;
   localparam logic [3:0] RETRY_MAX = 4'hF;
   localparam logic [12:0] LINK_TO_MAX_MS = 13'h1388;
   localparam logic [7:0] EVT_CNT_MIN = 8'h01;
   localparam logic [7:0] EVT_CNT_MAX = 8'hC8;
   localparam logic [15:0] EVT_AGE_MAX_MS = 16'hEA60;
   localparam logic [15:0] EVT_TO_MIN_MS = 16'h03E8;
   localparam logic [15:0] EVT_TO_MAX_MS = 16'hC350;
   localparam logic [15:0] ADDR_MAX = 16'hFFFE;
   localparam logic [14:0] DB_MAX = 15'h7FFF;
   localparam logic [14:0] SBO_MAX_MS = 15'h7530;
   localparam logic [1:0] CLASS_MAX = 2'h3;
   // ************************************************************
   // reset values
   // ************************************************************
   localparam logic [9:0] RST_MIN_IDLE = 10'h032;
   localparam logic [9:0] RST_MAX_IDLE = 10'h064;
   localparam logic [15:0] RST_PRE = 16'h0000;
   localparam logic [15:0] RST_POST = 16'h0000;
   localparam logic [3:0] RST_RETRY = 4'h3;
   localparam logic [12:0] RST_LINK_TO = 13'h03E8;
   localparam logic [7:0] RST_EVT_CNT = 8'h0A;
   localparam logic [15:0] RST_EVT_AGE = 16'h07D0;
   localparam logic [15:0] RST_EVT_TO = 16'h07D0;
   localparam logic [15:0] RST_ADDR = 16'h0000;
   localparam logic [1:0] RST_CLASS = 2'h2;
   localparam logic [14:0] RST_DB = 15'h0064;
   localparam logic [14:0] RST_SBO = 15'h03E8;
   localparam logic [15:0] LFSR_SEED = 16'hACE1;
   // ************************************************************
   // carriers
   // ************************************************************
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } dsma_apb_req_type;
   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } dsma_apb_rsp_type;
   typedef struct packed {
      logic [3:0] linkRetryCount;
      logic [12:0] linkConfirmTimeout;
      logic [7:0] eventCountThreshold;
      logic [15:0] oldestEventAgeLimit;
      logic [15:0] eventConfirmTimeout;
      logic [15:0] reportDestAddress;
      logic unsolicitedEnable;
      logic powerupUnsolicitedEnable;
      logic extendedProtocolMode;
      logic [1:0] analogEventClass;
      logic [1:0] binaryEventClass;
      logic [1:0] counterEventClass;
      logic [14:0] currentDeadband;
      logic [14:0] voltageDeadband;
      logic [14:0] miscDeadband;
      logic [14:0] selectOperateTimeout;
   } dsma_cfg_type;
   typedef enum logic [2:0] {ST_IDLE, ST_HOLDOFF, ST_PRE, ST_SEND, ST_POST} dsma_state_type;
endpackage
`default_nettype wire

/* core/dsma_media_access.sv */
/*
 media-access and timing control for a serial network link, with its settings behind an APB slave.
 assumes the uart that sends bytes sits outside: it sends while txGo is high and pulses txLastDone.
 cts and rxd come from pins and are synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none
module dsma_media_access #(
   parameter int RX_QUIET_CYCLES = 16,
   parameter int MS_CYCLES = dsma_pkg::TICK_CYCLES
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire dsma_pkg::dsma_apb_req_type apbReq,
   output dsma_pkg::dsma_apb_rsp_type apbRsp,
   input wire logic ctsPin,
   input wire logic rxdPin,
   input wire logic txRequest,
   input wire logic txLastDone,
   output logic txGo,
   output logic rtsPin,
   output dsma_pkg::dsma_cfg_type cfgOut,
   output logic carrierBusy
);
   import dsma_pkg::*;
   // ************************************************************
   // settings registers
   // ************************************************************
   logic [1:0] protoSel_reg;
   logic [9:0] minIdle_reg, maxIdle_reg;
   logic [15:0] preSettle_reg, postSettle_reg;
   logic [3:0] retry_reg;
   logic [12:0] linkTo_reg;
   logic [7:0] evtCnt_reg;
   logic [15:0] evtAge_reg, evtTo_reg, repAddr_reg;
   logic unsolicited_enable_reg, powerup_unsolicited_enable_reg;
   logic [1:0] clsA_reg, clsB_reg, clsC_reg;
   logic [14:0] dbCur_reg, dbVolt_reg, dbMisc_reg, sbo_reg;
   logic wrEn, rdSel;
   assign wrEn = apbReq.psel & apbReq.penable & apbReq.pwrite;
   assign rdSel = apbReq.psel & ~apbReq.pwrite;

   function automatic logic [15:0] clip16(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
      clip16 = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         protoSel_reg <= PORT_PROTOCOL_SELECT_STANDARD;
         minIdle_reg <= RST_MIN_IDLE;
         maxIdle_reg <= RST_MAX_IDLE;
         preSettle_reg <= RST_PRE;
         postSettle_reg <= RST_POST;
         retry_reg <= RST_RETRY;
         linkTo_reg <= RST_LINK_TO;
         evtCnt_reg <= RST_EVT_CNT;
         evtAge_reg <= RST_EVT_AGE;
         evtTo_reg <= RST_EVT_TO;
         unsolicited_enable_reg <= 1'b0;
         powerup_unsolicited_enable_reg <= 1'b0;
         repAddr_reg <= RST_ADDR;
         clsA_reg <= RST_CLASS;
         clsB_reg <= RST_CLASS;
         clsC_reg <= RST_CLASS;
         dbCur_reg <= RST_DB;
         dbVolt_reg <= RST_DB;
         dbMisc_reg <= RST_DB;
         sbo_reg <= RST_SBO;
      end else if (wrEn) begin
         case (apbReq.paddr)
            OFF_CTRL: begin
               protoSel_reg <= apbReq.pwdata[1:0];
               unsolicited_enable_reg <= apbReq.pwdata[4];
               powerup_unsolicited_enable_reg <= apbReq.pwdata[5];
            end
            OFF_IDLE: begin
               minIdle_reg <= 10'(clip16({6'h00, apbReq.pwdata[9:0]}, 16'h0000, {6'h00, IDLE_MAX_MS}));
               maxIdle_reg <= 10'(clip16({6'h00, apbReq.pwdata[25:16]}, 16'h0000, {6'h00, IDLE_MAX_MS}));
            end
            OFF_SETTLE: begin
               preSettle_reg <= (apbReq.pwdata[15:0] == PRE_OFF) ? PRE_OFF :
                                clip16(apbReq.pwdata[15:0], 16'h0000, PRE_MAX_MS);
               postSettle_reg <= clip16(apbReq.pwdata[31:16], 16'h0000, POST_MAX_MS);
            end
            OFF_LINK: begin
               retry_reg <= apbReq.pwdata[3:0];
               linkTo_reg <= 13'(clip16({3'h0, apbReq.pwdata[28:16]}, 16'h0000, {3'h0, LINK_TO_MAX_MS}));
            end
            OFF_EVENT: begin
               evtCnt_reg <= 8'(clip16({8'h00, apbReq.pwdata[7:0]}, {8'h00, EVT_CNT_MIN},
                                    {8'h00, EVT_CNT_MAX}));
               evtAge_reg <= clip16(apbReq.pwdata[31:16], 16'h0000, EVT_AGE_MAX_MS);
            end
            OFF_REPORT: begin
               repAddr_reg <= clip16(apbReq.pwdata[15:0], 16'h0000, ADDR_MAX);
               evtTo_reg <= clip16(apbReq.pwdata[31:16], EVT_TO_MIN_MS, EVT_TO_MAX_MS);
            end
            OFF_CLASS: begin
               clsA_reg <= apbReq.pwdata[1:0];
               clsB_reg <= apbReq.pwdata[3:2];
               clsC_reg <= apbReq.pwdata[5:4];
            end
            OFF_DBCUR: dbCur_reg <= apbReq.pwdata[14:0];
            OFF_DBVOLT: dbVolt_reg <= apbReq.pwdata[14:0];
            OFF_DBMISC: dbMisc_reg <= apbReq.pwdata[14:0];
            OFF_SBO: sbo_reg <= 15'(clip16({1'b0, apbReq.pwdata[14:0]}, 16'h0000, {1'b0, SBO_MAX_MS}));
            default: begin
            end
         endcase
      end
   end

   // ************************************************************
   // configuration out
   // ************************************************************
   logic extMode;
   assign extMode = (protoSel_reg == PORT_PROTOCOL_SELECT_EXTENDED);
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         cfgOut <= '0;
      end else begin
         cfgOut.linkRetryCount <= retry_reg;
         cfgOut.linkConfirmTimeout <= linkTo_reg;
         cfgOut.eventCountThreshold <= evtCnt_reg;
         cfgOut.oldestEventAgeLimit <= evtAge_reg;
         cfgOut.eventConfirmTimeout <= evtTo_reg;
         cfgOut.reportDestAddress <= repAddr_reg;
         cfgOut.unsolicitedEnable <= unsolicited_enable_reg;
         cfgOut.powerupUnsolicitedEnable <= powerup_unsolicited_enable_reg;
         cfgOut.extendedProtocolMode <= extMode;
         // extended-only settings except selectOperateTimeout read as zero outside extended mode
         cfgOut.analogEventClass <= extMode ? clsA_reg : 2'h0;
         cfgOut.binaryEventClass <= extMode ? clsB_reg : 2'h0;
         cfgOut.counterEventClass <= extMode ? clsC_reg : 2'h0;
         cfgOut.currentDeadband <= extMode ? dbCur_reg : 15'h0000;
         cfgOut.voltageDeadband <= extMode ? dbVolt_reg : 15'h0000;
         cfgOut.miscDeadband <= extMode ? dbMisc_reg : 15'h0000;
         cfgOut.selectOperateTimeout <= sbo_reg;
      end
   end

   // ************************************************************
   // pin synchronisers and carrier detect
   // ************************************************************
   logic [1:0] ctsSync_reg, rxdSync_reg;
   logic rxdPrev_reg;
   logic [15:0] rxQuiet_reg;
   logic noHandshake;
   assign noHandshake = (preSettle_reg == PRE_OFF);
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         ctsSync_reg <= 2'h0;
         rxdSync_reg <= 2'h3;
         rxdPrev_reg <= 1'b1;
      end else begin
         ctsSync_reg <= {ctsSync_reg[0], ctsPin};
         rxdSync_reg <= {rxdSync_reg[0], rxdPin};
         rxdPrev_reg <= rxdSync_reg[1];
      end
   end
   // rx activity: any line edge or low level restarts a quiet window, so a whole character reads as busy
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         rxQuiet_reg <= 16'h0000;
      end else if (!rxdSync_reg[1] || (rxdPrev_reg != rxdSync_reg[1])) begin
         rxQuiet_reg <= RX_QUIET_CYCLES[15:0];
      end else if (rxQuiet_reg != 16'h0000) begin
         rxQuiet_reg <= rxQuiet_reg - 16'h0001;
      end
   end
   // cts counts as carrier whenever the handshake is on, before or after rts is raised; with pre settle at PRE_OFF it is ignored
   assign carrierBusy = ((ctsSync_reg[1] & ~noHandshake) | (rxQuiet_reg != 16'h0000));

   // ************************************************************
   // lfsr and millisecond tick
   // ************************************************************
   logic [15:0] lfsr_reg;
   logic [31:0] msDiv_reg;
   logic msTick;
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         lfsr_reg <= LFSR_SEED;
      end else begin
         lfsr_reg <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
      end
   end
   assign msTick = (msDiv_reg == 32'(MS_CYCLES - 1));
   always_ff @(posedge core_clk) begin
      if (!nrst || msTick) begin
         msDiv_reg <= 32'h00000000;
      end else begin
         msDiv_reg <= msDiv_reg + 32'h00000001;
      end
   end
   // uniform pick in [min, max]: span scaled by lfsr/65536; a swapped pair falls back to min
   logic [9:0] idleSpan, holdPick;
   logic [25:0] scaled;
   assign idleSpan = (maxIdle_reg > minIdle_reg) ? (maxIdle_reg - minIdle_reg) : 10'h000;
   assign scaled = ({16'h0000, idleSpan} + 26'h0000001) * {10'h000, lfsr_reg};
   assign holdPick = minIdle_reg + scaled[25:16];

   // ************************************************************
   // access state machine
   // ************************************************************
   dsma_state_type state_reg;
   logic [15:0] msLeft_reg;
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         state_reg <= ST_IDLE;
         msLeft_reg <= 16'h0000;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (txRequest && !carrierBusy) begin
                  state_reg <= ST_HOLDOFF;
                  msLeft_reg <= {6'h00, holdPick};
               end
            end
            ST_HOLDOFF: begin
               if (carrierBusy) begin
                  msLeft_reg <= {6'h00, holdPick};
               end else if (msLeft_reg == 16'h0000) begin
                  state_reg <= ST_PRE;
                  msLeft_reg <= noHandshake ? 16'h0000 : preSettle_reg;
               end else if (msTick) begin
                  msLeft_reg <= msLeft_reg - 16'h0001;
               end
            end
            ST_PRE: begin
               if (msLeft_reg == 16'h0000) begin
                  state_reg <= ST_SEND;
               end else if (msTick) begin
                  msLeft_reg <= msLeft_reg - 16'h0001;
               end
            end
            ST_SEND: begin
               if (txLastDone) begin
                  state_reg <= ST_POST;
                  msLeft_reg <= postSettle_reg;
               end
            end
            ST_POST: begin
               if (txRequest) begin
                  state_reg <= ST_SEND;
               end else if (msLeft_reg == 16'h0000) begin
                  state_reg <= ST_IDLE;
               end else if (msTick) begin
                  msLeft_reg <= msLeft_reg - 16'h0001;
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         rtsPin <= 1'b0;
         txGo <= 1'b0;
      end else begin
         rtsPin <= noHandshake | (state_reg == ST_PRE) | (state_reg == ST_SEND) | (state_reg == ST_POST);
         txGo <= (state_reg == ST_SEND) & ~txLastDone;
      end
   end

   // ************************************************************
   // apb read and answer
   // ************************************************************
   logic [31:0] rdData;
   always_comb begin
      rdData = 32'h00000000;
      case (apbReq.paddr)
         OFF_CTRL: rdData = {26'h0, powerup_unsolicited_enable_reg, unsolicited_enable_reg, 2'h0, protoSel_reg};
         OFF_IDLE: rdData = {6'h00, maxIdle_reg, 6'h00, minIdle_reg};
         OFF_SETTLE: rdData = {postSettle_reg, preSettle_reg};
         OFF_LINK: rdData = {3'h0, linkTo_reg, 12'h000, retry_reg};
         OFF_EVENT: rdData = {evtAge_reg, 8'h00, evtCnt_reg};
         OFF_REPORT: rdData = {evtTo_reg, repAddr_reg};
         OFF_CLASS: rdData = {26'h0, clsC_reg, clsB_reg, clsA_reg};
         OFF_DBCUR: rdData = {17'h0, dbCur_reg};
         OFF_DBVOLT: rdData = {17'h0, dbVolt_reg};
         OFF_DBMISC: rdData = {17'h0, dbMisc_reg};
         OFF_SBO: rdData = {17'h0, sbo_reg};
         OFF_STATUS: rdData = {10'h000, msLeft_reg, rtsPin, carrierBusy, txGo, state_reg};
         default: rdData = 32'h00000000;
      endcase
   end
   logic unmapped;
   logic [31:0] rdWord_reg;
   assign unmapped = (apbReq.paddr > OFF_STATUS) || (apbReq.paddr[1:0] != 2'h0);
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         rdWord_reg <= 32'h00000000;
      end else if (rdSel && !apbReq.penable) begin
         rdWord_reg <= rdData;
      end
   end
   // zero wait states: pready high during every access phase
   assign apbRsp = '{pready: 1'b1, pslverr: apbReq.psel & apbReq.penable & unmapped, prdata: rdWord_reg};
endmodule
`default_nettype wire

/* sim/dsma_media_access_sva.sv */
/*
 checker for the media-access block, bound to its top ports.
 assumes settings reach the block only through apb writes.
*/
`timescale 1ns/1ps
`default_nettype none
module dsma_media_access_sva #(
   parameter int RX_QUIET_CYCLES = 16,
   parameter int MS_CYCLES = dsma_pkg::TICK_CYCLES
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire dsma_pkg::dsma_apb_req_type apbReq,
   input wire dsma_pkg::dsma_apb_rsp_type apbRsp,
   input wire logic ctsPin,
   input wire logic rxdPin,
   input wire logic txRequest,
   input wire logic txLastDone,
   input wire logic txGo,
   input wire logic rtsPin,
   input wire dsma_pkg::dsma_cfg_type cfgOut,
   input wire logic carrierBusy
);
   import dsma_pkg::*;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   // ********
   // mirrored settings and elapsed-time counters
   // ********
   logic wr;
   logic noHs;
   logic ext;
   logic [9:0] minIdle;
   logic [15:0] preMs;
   logic [15:0] postMs;
   int quietCnt;
   int rtsCnt;
   int doneCnt;
   int rxCnt;
   assign wr = apbReq.psel && apbReq.penable && apbReq.pwrite && apbRsp.pready;
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         noHs <= 1'b0;
         ext <= 1'b0;
         minIdle <= RST_MIN_IDLE;
         preMs <= RST_PRE;
         postMs <= RST_POST;
      end else if (wr && apbReq.paddr == OFF_SETTLE) begin
         noHs <= apbReq.pwdata[15:0] == PRE_OFF;
         preMs <= (apbReq.pwdata[15:0] == PRE_OFF) ? 16'h0000 : apbReq.pwdata[15:0];
         postMs <= apbReq.pwdata[31:16];
      end else if (wr && apbReq.paddr == OFF_IDLE) begin
         minIdle <= apbReq.pwdata[9:0];
      end else if (wr && apbReq.paddr == OFF_CTRL) begin
         ext <= apbReq.pwdata[1:0] == PORT_PROTOCOL_SELECT_EXTENDED;
      end
   end
   // runs stay far below int range, so no saturation is needed
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         quietCnt <= 0;
         rtsCnt <= 0;
         doneCnt <= 0;
         rxCnt <= 0;
      end else begin
         quietCnt <= carrierBusy ? 0 : quietCnt + 1;
         rtsCnt <= rtsPin ? rtsCnt + 1 : 0;
         doneCnt <= txLastDone ? 0 : doneCnt + 1;
         rxCnt <= $changed(rxdPin) ? 0 : rxCnt + 1;
      end
   end
   // ********
   // properties
   // ********
   sequence sDoneThenReq;
      txLastDone ##2 (txRequest && postMs != 16'h0000);
   endsequence
   AST_BUSY_BLOCKS_START: assert property ((!noHs && carrierBusy && !rtsPin) [*3] |=> !rtsPin)
      else $error("rts rose while carrier present");
   AST_CTS_IS_CARRIER: assert property ((!noHs && ctsPin) [*3] |-> carrierBusy)
      else $error("cts high but carrier not seen");
   AST_RX_IS_CARRIER: assert property ($fell(rxdPin) |-> ##[1:4] carrierBusy)
      else $error("receive activity not seen as carrier");
   AST_MIN_HOLDOFF: assert property ($rose(rtsPin) && !noHs |->
      quietCnt + MS_CYCLES >= int'(minIdle) * MS_CYCLES)
      else $error("hold-off shorter than minimum");
   AST_QUIET_NOT_BUSY: assert property ((noHs && rxCnt > RX_QUIET_CYCLES + 4) [*3] |-> !carrierBusy)
      else $error("carrier seen on a quiet line");
   AST_PRE_SETTLE: assert property ($rose(txGo) |->
      rtsCnt + MS_CYCLES >= int'(preMs) * MS_CYCLES)
      else $error("first byte before pre settle");
   AST_POST_HOLD: assert property ($fell(rtsPin) |->
      doneCnt + MS_CYCLES >= int'(postMs) * MS_CYCLES)
      else $error("rts dropped before post settle");
   AST_RESEND_NOW: assert property (sDoneThenReq |-> ##[0:3] (txGo && rtsPin))
      else $error("send during post settle delayed");
   AST_NOHS_RTS_HIGH: assert property (noHs [*3] |-> rtsPin)
      else $error("rts low with handshake off");
   AST_STD_HIDES_EXT: assert property (!ext [*2] |-> !cfgOut.extendedProtocolMode &&
      cfgOut.analogEventClass == 2'h0 && cfgOut.currentDeadband == 15'h0000)
      else $error("extended settings shown in standard mode");
endmodule
bind dsma_media_access dsma_media_access_sva #(
   .RX_QUIET_CYCLES(RX_QUIET_CYCLES),
   .MS_CYCLES(MS_CYCLES)
) uSva (
   .core_clk(core_clk), .nrst(nrst), .apbReq(apbReq), .apbRsp(apbRsp), .ctsPin(ctsPin),
   .rxdPin(rxdPin), .txRequest(txRequest), .txLastDone(txLastDone), .txGo(txGo),
   .rtsPin(rtsPin), .cfgOut(cfgOut), .carrierBusy(carrierBusy)
);
`default_nettype wire

/* sim/dsma_line_model.sv */
/*
 line-side model: byte sender, carrier line and receive line.
 assumes the bench commands carrier and receive activity.
*/
`timescale 1ns/1ps
`default_nettype none
module dsma_line_model (
   input wire logic core_clk,
   input wire logic txGo,
   input wire logic [7:0] msgLen,
   input wire logic ctsCmd,
   input wire logic rxCmd,
   output logic ctsPin,
   output logic rxdPin,
   output logic txLastDone
);
   int byteCnt;
   initial begin
      byteCnt = 0;
      ctsPin = 1'b0;
      rxdPin = 1'b1;
      txLastDone = 1'b0;
   end
   // a message lasts msgLen cycles of txGo; done stands one cycle
   always @(posedge core_clk) begin
      txLastDone <= txGo && byteCnt == int'(msgLen) - 1;
      byteCnt <= (txGo && byteCnt < int'(msgLen) - 1) ? byteCnt + 1 : 0;
   end
   // receive activity toggles rxd every cycle so no level is ever reused by chance; cts holds the commanded level
   always @(posedge core_clk) begin
      ctsPin <= ctsCmd;
      rxdPin <= rxCmd ? ~rxdPin : 1'b1;
   end
endmodule
`default_nettype wire

/* sim/test_dsma_media_access.sv */
/*
 bench for the media-access block: apb master, line model, scenarios.
 assumes a 50 MHz clock and a millisecond shortened to four cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module test_dsma_media_access;
   import dsma_pkg::*;
   localparam int MS = 4;
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   dsma_apb_req_type apbReq = '0;
   dsma_apb_rsp_type apbRsp;
   dsma_cfg_type cfgOut;
   logic ctsPin, rxdPin, txLastDone, txGo, rtsPin, carrierBusy;
   logic txRequest = 1'b0;
   logic ctsCmd = 1'b0;
   logic rxCmd = 1'b0;
   logic [7:0] msgLen = 8'h06;
   logic [31:0] rdData;
   logic rdErr;
   int err_count = 0;
   int total_checks = 0;
   int n;
   always #10 core_clk = ~core_clk;
   dsma_media_access #(.RX_QUIET_CYCLES(16), .MS_CYCLES(MS)) dut (
      .core_clk(core_clk), .nrst(nrst), .apbReq(apbReq), .apbRsp(apbRsp), .ctsPin(ctsPin),
      .rxdPin(rxdPin), .txRequest(txRequest), .txLastDone(txLastDone), .txGo(txGo),
      .rtsPin(rtsPin), .cfgOut(cfgOut), .carrierBusy(carrierBusy));
   dsma_line_model uLine (.core_clk(core_clk), .txGo(txGo), .msgLen(msgLen), .ctsCmd(ctsCmd),
      .rxCmd(rxCmd), .ctsPin(ctsPin), .rxdPin(rxdPin), .txLastDone(txLastDone));
   // ********
   // shared tasks
   // ********
   task finish_test();
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task check(input logic [31:0] got, input logic [31:0] expv);
      total_checks++;
      if (got !== expv) begin
         err_count++;
         $display("BAD %0t got %h expected %h", $time, got, expv);
      end
   endtask
   task checkIn(input int v, input int lo, input int hi);
      total_checks++;
      if (v < lo || v > hi) begin
         err_count++;
         $display("BAD %0t count %0d outside %0d..%0d", $time, v, lo, hi);
      end
   endtask
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk);
      apbReq.psel <= 1'b1;
      apbReq.pwrite <= wr;
      apbReq.paddr <= a;
      apbReq.pwdata <= d;
      @(posedge core_clk);
      apbReq.penable <= 1'b1;
      do begin
         @(posedge core_clk);
      end while (apbRsp.pready !== 1'b1);
      rdData = apbRsp.prdata;
      rdErr = apbRsp.pslverr;
      apbReq.psel <= 1'b0;
      apbReq.penable <= 1'b0;
   endtask
   // which: 0 rts, 1 txGo, 2 done; n gives the edges waited
   task waitSig(input int which, input logic lvl, input int lim);
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while ((which == 0 ? rtsPin : which == 1 ? txGo : txLastDone) !== lvl && n < lim);
   endtask
   // ********
   // scenarios
   // ********
   task testDefaults();
      logic [31:0] expv [11];
      expv = '{32'h0, {6'h0, RST_MAX_IDLE, 6'h0, RST_MIN_IDLE}, {RST_POST, RST_PRE},
         {3'h0, RST_LINK_TO, 12'h0, RST_RETRY}, {RST_EVT_AGE, 8'h0, RST_EVT_CNT},
         {RST_EVT_TO, RST_ADDR}, {26'h0, RST_CLASS, RST_CLASS, RST_CLASS},
         {17'h0, RST_DB}, {17'h0, RST_DB}, {17'h0, RST_DB}, {17'h0, RST_SBO}};
      for (int i = 0; i < 11; i++) begin
         apb(1'b0, 12'(4 * i), 32'h0);
         check(rdData, expv[i]);
      end
      apb(1'b0, 12'h030, 32'h0);
      check(rdData, 32'h0);
      check({31'h0, rdErr}, 32'h1);
      check({cfgOut.linkRetryCount, cfgOut.eventCountThreshold}, {RST_RETRY, RST_EVT_CNT});
   endtask
   task testLimits();
      apb(1'b1, OFF_LINK, {3'h0, LINK_TO_MAX_MS, 12'h0, RETRY_MAX});
      apb(1'b1, OFF_EVENT, 32'h0000_00FF);
      apb(1'b1, OFF_REPORT, 32'h0000_FFFF);
      apb(1'b1, OFF_CTRL, 32'h0000_0031);
      apb(1'b0, OFF_EVENT, 32'h0);
      check(rdData, {24'h0, EVT_CNT_MAX});
      apb(1'b0, OFF_REPORT, 32'h0);
      check(rdData, {EVT_TO_MIN_MS, ADDR_MAX});
      check({cfgOut.linkRetryCount, cfgOut.linkConfirmTimeout}, {RETRY_MAX, LINK_TO_MAX_MS});
      check({cfgOut.extendedProtocolMode, cfgOut.unsolicitedEnable, cfgOut.powerupUnsolicitedEnable,
         cfgOut.analogEventClass, cfgOut.counterEventClass}, {3'b111, RST_CLASS, RST_CLASS});
      check({cfgOut.currentDeadband, cfgOut.miscDeadband}, {RST_DB, RST_DB});
      apb(1'b1, OFF_EVENT, 32'h0);
      apb(1'b0, OFF_EVENT, 32'h0);
      check(rdData, {24'h0, EVT_CNT_MIN});
      apb(1'b1, OFF_CTRL, 32'h0);
   endtask
   task testHoldoff();
      txRequest <= 1'b1;
      waitSig(0, 1'b1, 600);
      checkIn(n, (RST_MIN_IDLE - 1) * MS, (RST_MAX_IDLE + 2) * MS);
      waitSig(1, 1'b1, 10);
      checkIn(n, 1, 3);
      waitSig(2, 1'b1, 50);
      txRequest <= 1'b0;
      waitSig(0, 1'b0, 10);
      checkIn(n, 1, 4);
   endtask
   task testCarrier();
      apb(1'b1, OFF_IDLE, 32'h000A_000A);
      ctsCmd <= 1'b1;
      txRequest <= 1'b1;
      waitSig(0, 1'b1, 300);
      checkIn(n, 300, 300);
      ctsCmd <= 1'b0;
      rxCmd <= 1'b1;
      waitSig(0, 1'b1, 200);
      checkIn(n, 200, 200);
      rxCmd <= 1'b0;
      waitSig(0, 1'b1, 200);
      checkIn(n, 16 + 8 * MS, 16 + 12 * MS + 8);
      waitSig(2, 1'b1, 60);
      txRequest <= 1'b0;
      waitSig(0, 1'b0, 10);
   endtask
   task testSettle();
      msgLen <= 8'h02;
      apb(1'b1, OFF_SETTLE, 32'h0005_0005);
      txRequest <= 1'b1;
      waitSig(0, 1'b1, 200);
      waitSig(1, 1'b1, 60);
      checkIn(n, 4 * MS, 5 * MS + 3);
      waitSig(2, 1'b1, 50);
      waitSig(1, 1'b0, 5);
      waitSig(1, 1'b1, 10);
      checkIn(n, 1, 3);
      waitSig(2, 1'b1, 50);
      txRequest <= 1'b0;
      waitSig(0, 1'b0, 60);
      checkIn(n, 4 * MS, 5 * MS + 4);
      apb(1'b1, OFF_SETTLE, 32'h0);
   endtask
   task testNoHs();
      apb(1'b1, OFF_SETTLE, {16'h0002, PRE_OFF});
      waitSig(0, 1'b1, 5);
      checkIn(n, 1, 4);
      ctsCmd <= 1'b1;
      txRequest <= 1'b1;
      waitSig(1, 1'b1, 100);
      checkIn(n, 9 * MS, 12 * MS + 4);
      waitSig(2, 1'b1, 50);
      txRequest <= 1'b0;
      waitSig(0, 1'b0, 40);
      checkIn(n, 40, 40);
      ctsCmd <= 1'b0;
      apb(1'b1, OFF_SETTLE, 32'h0);
      waitSig(0, 1'b0, 6);
      checkIn(n, 1, 5);
   endtask
   // ********
   // main sequence and watchdog
   // ********
   initial begin
      repeat (16) @(posedge core_clk);
      nrst <= 1'b1;
      testDefaults();
      testLimits();
      testHoldoff();
      testCarrier();
      testSettle();
      testNoHs();
      finish_test();
   end
   initial begin
      #(20 * 30000);
      err_count++;
      finish_test();
   end
endmodule
`default_nettype wire
